// *** ddr2_lp_pkg.sv ***
// constants and types shared by the memory-side and controller-side ends
// Functional notes
// - async cke drop invalidates stored contents
// - controller waits delay before stopping clocks
// - stable clocks, then full reinit steps
// - clock change only in precharge powerdown (controller does not check for open rows)
// - two cycles after cke low before change
// - odt and cke held low during change
// - stable new clocks before powerdown exit
// - dll reset via extended mode set
// - optional mode set for new frequency
// - odt off through dll relock wait
// - bursts always run to completion
// - cs low, others high decodes nop
// - nop leaves running burst untouched
// - controller issues nop when idle
// - cs high is deselect, like nop
// - powerdown entry/exit on cke with nop
// - idle banks precharge powerdown, dll off
package ddr2_lp_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned DELAY_NS         = 20;
    localparam int unsigned DELAY_CYC        =
        (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FREQ_WAIT_CYC    = 2;
    localparam int unsigned INIT_FIRST_STEP  = 4;
    localparam int unsigned INIT_LAST_STEP   = 13;
    localparam int unsigned INIT_STEPS       =
        INIT_LAST_STEP - INIT_FIRST_STEP + 1;
    localparam int unsigned DLL_LOCK_CYC     = 200;
    localparam int unsigned BURST_LEN_BEATS  = 4;
    localparam int unsigned CLK_STABLE_CYC   = 4;
    localparam int unsigned CNT_W            = 16;

    // command codes on {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        CMD_MRS  = 3'h0,
        CMD_REF  = 3'h1,
        CMD_PRE  = 3'h2,
        CMD_ACT  = 3'h3,
        CMD_WR   = 3'h4,
        CMD_RD   = 3'h5,
        CMD_BST  = 3'h6,
        CMD_NOP  = 3'h7
    } cmd_type;

    localparam logic [1:0] BA_MRS  = 2'h0;
    localparam logic [1:0] BA_EMRS = 2'h1;
    localparam int unsigned DLL_RESET_BIT = 8;

    // returns true for nop or deselect
    function automatic logic is_idle_cmd(input logic cs_n,
                                         input logic [2:0] rcw);
        return cs_n || (rcw == 3'h7);
    endfunction : is_idle_cmd
endpackage : ddr2_lp_pkg

// *** ddr2_cmd_if.sv ***
// command and clock link between controller and memory
`timescale 1ns/1ps
interface ddr2_cmd_if;
    logic       clk_run;
    logic       cke;
    logic       odt;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] ba;
    logic [13:0] addr;

    modport ctrl (output clk_run, cke, odt, cs_n, ras_n, cas_n, we_n,
                  ba, addr);
    modport mem  (input  clk_run, cke, odt, cs_n, ras_n, cas_n, we_n,
                  ba, addr);
endinterface : ddr2_cmd_if

// *** ddr2_mem_end.sv ***
// memory-side command decoder and power state tracker
`timescale 1ns/1ps
module ddr2_mem_end
    import ddr2_lp_pkg::*;
#(
    parameter int unsigned BURST_BEATS = BURST_LEN_BEATS
) (
    input  wire logic clk,
    input  wire logic reset_n,
    ddr2_cmd_if.mem   link,
    output logic      cmd_valid,
    output logic [2:0] cmd_code,
    output logic      burst_busy,
    output logic      powered_down,
    output logic      precharge_pd,
    output logic      dll_on,
    output logic      contents_valid,
    output logic      cmd_error
);
    initial begin
        if (BURST_BEATS < 1 || BURST_BEATS > 255)
            $error("burst length out of range");
    end

    logic [7:0] burst_q, burst_d;
    logic       pd_q, prepd_q, dll_q, valid_q, err_q, row_open_q;
    logic       cmd_valid_q;
    logic [2:0] cmd_q;
    logic       cke_prev_q;

    // decode of the sampled command
    wire [2:0] rcw       = {link.ras_n, link.cas_n, link.we_n};
    wire       idle_cmd  = is_idle_cmd(link.cs_n, rcw);
    wire       live      = link.cke && !pd_q;
    wire       real_cmd  = live && !idle_cmd;
    wire       is_rd     = real_cmd && rcw == CMD_RD;
    wire       is_wr     = real_cmd && rcw == CMD_WR;
    wire       is_act    = real_cmd && rcw == CMD_ACT;
    wire       is_pre    = real_cmd && rcw == CMD_PRE;
    wire       is_emrs   = real_cmd && rcw == CMD_MRS && link.ba == BA_EMRS;
    wire       pd_enter  = cke_prev_q && !link.cke && idle_cmd
                           && burst_q == 8'h0;
    wire       pd_exit   = pd_q && link.cke && idle_cmd;
    wire       async_low = cke_prev_q && !link.cke && !pd_enter;
    wire       cut_try   = real_cmd && burst_q != 8'h0;

    // burst countdown keeps running through nop and deselect
    always_comb begin
        burst_d = (burst_q != 8'h0) ? burst_q - 8'h1 : 8'h0;
        if ((is_rd || is_wr) && burst_q == 8'h0)
            burst_d = 8'(BURST_BEATS);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_q    <= 8'h0;
            cke_prev_q <= 1'b0;
            cmd_q      <= 3'h7;
            cmd_valid_q <= 1'b0;
        end else begin
            burst_q    <= burst_d;
            cke_prev_q <= link.cke;
            cmd_q      <= rcw;
            cmd_valid_q <= real_cmd && !cut_try;
        end
    end

    // power-down state, dll and contents tracking
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pd_q       <= 1'b0;
            prepd_q    <= 1'b0;
            dll_q      <= 1'b0;
            valid_q    <= 1'b0;
            err_q      <= 1'b0;
            row_open_q <= 1'b0;
        end else begin
            if (is_act)
                row_open_q <= 1'b1;
            else if (is_pre)
                row_open_q <= 1'b0;
            if (pd_enter) begin
                pd_q    <= 1'b1;
                prepd_q <= !row_open_q;
                if (!row_open_q)
                    dll_q <= 1'b0;
            end else if (pd_exit) begin
                pd_q    <= 1'b0;
                prepd_q <= 1'b0;
            end
            if (is_emrs && link.addr[DLL_RESET_BIT])
                dll_q <= 1'b1;
            if (async_low)
                valid_q <= 1'b0;
            else if (is_emrs)
                valid_q <= 1'b1;
            err_q <= cut_try;
        end
    end

    assign cmd_valid      = cmd_valid_q;
    assign cmd_code       = cmd_q;
    assign burst_busy     = burst_q != 8'h0;
    assign powered_down   = pd_q;
    assign precharge_pd   = prepd_q;
    assign dll_on         = dll_q;
    assign contents_valid = valid_q;
    assign cmd_error      = err_q;
endmodule : ddr2_mem_end

// *** ddr2_ctrl_end.sv ***
// controller-side power-down, clock change and recovery sequencer
`timescale 1ns/1ps
module ddr2_ctrl_end
    import ddr2_lp_pkg::*;
#(
    parameter int unsigned DLL_LOCK = DLL_LOCK_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    ddr2_cmd_if.ctrl         link,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [2:0]  req_cmd,
    input  wire logic [13:0] req_addr,
    input  wire logic        freq_change_req,
    input  wire logic        need_mrs,
    input  wire logic        cke_fail,
    output logic             freq_clk_stop,
    output logic             busy
);
    // the shared down-counter must hold the whole lock wait
    initial begin
        if (DLL_LOCK < 1 || DLL_LOCK >= (1 << CNT_W))
            $error("dll lock count out of range");
    end

    typedef enum logic [3:0] {
        ST_RUN     = 4'h0,
        ST_PD      = 4'h1,
        ST_FWAIT   = 4'h2,
        ST_FCHG    = 4'h3,
        ST_STABLE  = 4'h4,
        ST_EMRS    = 4'h5,
        ST_MRS     = 4'h6,
        ST_LOCK    = 4'h7,
        ST_ADELAY  = 4'h8,
        ST_AREST   = 4'h9,
        ST_INIT    = 4'ha
    } state_type;

    // sequence state and one shared down-counter
    state_type   st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0]  burst_q;
    // registered pin drive and its next value
    logic        cke_q, odt_q, csn_q, clk_q;
    logic [2:0]  rcw_q;
    logic [1:0]  ba_q;
    logic [13:0] addr_q;
    logic        cke_d, odt_d, csn_d, clk_d;
    logic [2:0]  rcw_d;
    logic [1:0]  ba_d;
    logic [13:0] addr_d;

    wire cnt_zero = cnt_q == '0;
    wire burst_on = burst_q != 8'h0;
    // a read or write opens a burst that nothing may cut short
    wire burst_req = req_cmd == CMD_RD || req_cmd == CMD_WR;
    // no commands during bursts or sequences; reads wait for relock
    wire take = st_q == ST_RUN && req_valid && !burst_on
                && !freq_change_req && !cke_fail;

    // next-state and pin drive
    always_comb begin
        // hold levels, run the clock and drive nop unless told otherwise
        st_d   = st_q;
        cnt_d  = cnt_zero ? cnt_q : cnt_q - 1'b1;
        cke_d  = cke_q;
        odt_d  = odt_q;
        clk_d  = 1'b1;
        csn_d  = 1'b0;
        rcw_d  = CMD_NOP;
        ba_d   = 2'h0;
        addr_d = 14'h0;
        case (st_q)
            // normal running: failure first, then clock change, then work
            ST_RUN: begin
                if (cke_fail) begin
                    cke_d = 1'b0;
                    odt_d = 1'b0;  // no termination while clocks may stop
                    st_d  = ST_ADELAY;
                    cnt_d = CNT_W'(DELAY_CYC);
                end else if (freq_change_req && !burst_on) begin
                    cke_d = 1'b0;
                    odt_d = 1'b0;
                    st_d  = ST_FWAIT;
                    cnt_d = CNT_W'(FREQ_WAIT_CYC);
                end else begin
                    odt_d = 1'b1;  // termination on only in normal running
                    if (take) begin
                        rcw_d  = req_cmd;
                        addr_d = req_addr;
                    end
                end
            end
            // let cke low settle before the clock may change
            ST_FWAIT: if (cnt_zero) st_d = ST_FCHG;
            // clock held still while the frequency moves
            ST_FCHG: begin
                clk_d = 1'b0;  // cke and odt stay low
                if (!freq_change_req) begin
                    st_d  = ST_STABLE;
                    cnt_d = CNT_W'(CLK_STABLE_CYC);
                end
            end
            // new clock runs a while before cke returns
            ST_STABLE: if (cnt_zero) begin
                cke_d = 1'b1;
                st_d  = ST_EMRS;
            end
            // dll reset on the first command after exit
            ST_EMRS: begin
                rcw_d  = CMD_MRS;
                ba_d   = BA_EMRS;
                addr_d = 14'h1 << DLL_RESET_BIT;
                st_d   = need_mrs ? ST_MRS : ST_LOCK;
                cnt_d  = CNT_W'(DLL_LOCK);
            end
            // optional mode set for the new rate
            ST_MRS: begin
                rcw_d = CMD_MRS;
                ba_d  = BA_MRS;
                addr_d = req_addr;
                st_d  = ST_LOCK;
            end
            // dll relock wait, odt kept off and reads held back
            ST_LOCK: if (cnt_zero) st_d = ST_RUN;
            // wait out the delay before clocks stop after cke loss
            ST_ADELAY: begin
                if (cnt_zero) begin
                    clk_d = 1'b0;
                    if (!cke_fail) begin
                        st_d  = ST_AREST;
                        cnt_d = CNT_W'(CLK_STABLE_CYC);
                    end
                end
            end
            // clocks back and stable before cke rises again
            ST_AREST: if (cnt_zero) begin
                cke_d = 1'b1;
                st_d  = ST_INIT;
                cnt_d = CNT_W'(INIT_STEPS);
            end
            // re-initialisation commands, then a full relock
            ST_INIT: begin
                if (!cnt_zero) begin
                    rcw_d = CMD_MRS;
                    ba_d  = cnt_q[1:0];
                end else begin
                    st_d  = ST_LOCK;
                    cnt_d = CNT_W'(DLL_LOCK);
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    // state and output flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q   <= ST_RUN;
            cnt_q  <= '0;
            cke_q  <= 1'b1;
            odt_q  <= 1'b0;
            clk_q  <= 1'b1;
            csn_q  <= 1'b1;
            rcw_q  <= CMD_NOP;
            ba_q   <= 2'h0;
            addr_q <= 14'h0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            cke_q  <= cke_d;
            odt_q  <= odt_d;
            clk_q  <= clk_d;
            csn_q  <= csn_d;
            rcw_q  <= rcw_d;
            ba_q   <= ba_d;
            addr_q <= addr_d;
        end
    end

    // burst tracking so nothing is issued mid-burst
    // the count runs one cycle ahead of the memory's own
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            burst_q <= 8'h0;
        else if (take && burst_req)
            burst_q <= 8'(BURST_LEN_BEATS);
        else if (burst_on)
            burst_q <= burst_q - 8'h1;
    end

    // link pins come straight from flops
    assign link.clk_run = clk_q;
    assign link.cke     = cke_q;
    assign link.odt     = odt_q;
    assign link.cs_n    = csn_q;
    assign link.ras_n   = rcw_q[2];
    assign link.cas_n   = rcw_q[1];
    assign link.we_n    = rcw_q[0];
    assign link.ba      = ba_q;
    assign link.addr    = addr_q;

    // status decoded from state; handshake is take, from state, req_valid, burst count, freq_change_req and cke_fail
    assign req_ready    = take;
    assign freq_clk_stop = st_q == ST_FCHG;
    assign busy         = st_q != ST_RUN;
endmodule : ddr2_ctrl_end

// *** ddr2_lp_asserts.sv ***
// concurrent checks on the command link between the two ends
`timescale 1ns/1ps
module ddr2_lp_asserts
    import ddr2_lp_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_run,
    input wire logic        cke,
    input wire logic        odt,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [13:0] addr
);
    // command decode on the link pins
    wire logic [2:0] rcw  = {ras_n, cas_n, we_n};
    wire logic       idle = cs_n || (rcw == 3'h7);
    wire logic       rd   = !cs_n && (rcw == CMD_RD);
    wire logic       bst  = !cs_n && (rcw == CMD_RD || rcw == CMD_WR);
    wire logic       mrs  = !cs_n && (rcw == CMD_MRS);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_delay_clk_stop: assert property (
        $fell(clk_run) |-> !$past(cke) && !$past(cke, 2))
        else $error("clocks stopped too soon after cke loss");
    chk_stable_clk_wake: assert property (
        $rose(cke) |-> $past(clk_run) && $past(clk_run, 4))
        else $error("cke raised without stable clocks");
    chk_stop_odt_low: assert property (
        !clk_run |-> !cke && !odt)
        else $error("clock stopped with cke or odt high");
    chk_pd_entry_nop: assert property (
        $fell(cke) |-> idle)
        else $error("power-down entered without idle command");
    chk_pd_exit_nop: assert property (
        $rose(cke) |-> idle)
        else $error("power-down exit without idle command");
    chk_mode_after_exit: assert property (
        $rose(cke) |-> ##[1:4] mrs)
        else $error("no mode set after power-down exit");
    chk_odt_relock: assert property (
        $rose(cke) |-> !odt [*8])
        else $error("odt driven during relock");
    chk_no_read_relock: assert property (
        $rose(cke) |-> !rd [*8])
        else $error("read issued during relock");
    chk_burst_whole: assert property (
        bst |=> idle [*3])
        else $error("burst cut short");
    chk_pd_idle_cmd: assert property (
        !cke |-> idle)
        else $error("command issued while cke low");
endmodule : ddr2_lp_asserts

// *** ddr2_lowpower_clock_change_nop_test.sv ***
// self-checking bench joining controller and memory ends
`timescale 1ns/1ps
module ddr2_lowpower_clock_change_nop_test;
    import ddr2_lp_pkg::*;
    localparam int unsigned LOCK = 8;
    logic        clk             = 1'b0;
    logic        reset_n         = 1'b0;
    logic        req_valid       = 1'b0;
    logic [2:0]  req_cmd         = 3'h7;
    logic [13:0] req_addr        = 14'h0000;
    logic        freq_change_req = 1'b0;
    logic        need_mrs        = 1'b0;
    logic        cke_fail        = 1'b0;
    logic        req_ready, freq_clk_stop, busy, cmd_valid, burst_busy;
    logic        powered_down, precharge_pd, dll_on, contents_valid;
    logic        cmd_error;
    logic [2:0]  cmd_code;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          cycles     = 0;

    ddr2_cmd_if ddr2_cmd_if_inst ();
    ddr2_ctrl_end #(.DLL_LOCK(LOCK)) ddr2_ctrl_end_inst (.clk(clk),
        .reset_n(reset_n), .link(ddr2_cmd_if_inst), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
        .freq_change_req(freq_change_req), .need_mrs(need_mrs),
        .cke_fail(cke_fail), .freq_clk_stop(freq_clk_stop), .busy(busy));
    ddr2_mem_end ddr2_mem_end_inst (.clk(clk), .reset_n(reset_n),
        .link(ddr2_cmd_if_inst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .burst_busy(burst_busy),
        .powered_down(powered_down), .precharge_pd(precharge_pd),
        .dll_on(dll_on), .contents_valid(contents_valid),
        .cmd_error(cmd_error));
    ddr2_lp_asserts ddr2_lp_asserts_inst (.clk(clk), .reset_n(reset_n),
        .clk_run(ddr2_cmd_if_inst.clk_run), .cke(ddr2_cmd_if_inst.cke),
        .odt(ddr2_cmd_if_inst.odt), .cs_n(ddr2_cmd_if_inst.cs_n),
        .ras_n(ddr2_cmd_if_inst.ras_n), .cas_n(ddr2_cmd_if_inst.cas_n),
        .we_n(ddr2_cmd_if_inst.we_n), .ba(ddr2_cmd_if_inst.ba),
        .addr(ddr2_cmd_if_inst.addr));

    // 100 MHz clock
    always #5 clk = ~clk;

    // hang guard, generous against the longest recovery
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one request, optionally losing cke just after it is taken
    task automatic issue(input cmd_type cmd, input logic fail);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd   <= cmd;
        req_addr  <= 14'h0010;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid <= 1'b0;
        @(posedge clk);
        cke_fail <= fail;
        #1;  // the decode pulse stands for this one cycle
        check(3'(n < 50), 3'h1);
        check(3'(cmd_valid), 3'h1);
        check(cmd_code, cmd);
    endtask : issue

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1;
        check(3'(n < lim), 3'h1);
    endtask : wait_idle

    // idle link after reset decodes nothing
    task automatic t_idle();
        repeat (4) begin
            @(posedge clk);
            #1;
            check({cmd_valid, powered_down, cmd_error}, 3'h0);
        end
    endtask : t_idle

    // clock change in precharge power-down, then dll relock
    task automatic t_freq(input logic mrs);
        @(posedge clk);
        freq_change_req <= 1'b1;
        need_mrs        <= mrs;
        req_valid       <= 1'b1;  // a read held off by the whole change
        req_cmd         <= CMD_RD;
        repeat (6) @(posedge clk);
        #1;
        check(3'(freq_clk_stop), 3'h1);
        check(3'({ddr2_cmd_if_inst.cke, ddr2_cmd_if_inst.odt}), 3'h0);
        check({powered_down, precharge_pd, dll_on}, 3'h6);
        check(3'(req_ready), 3'h0);
        @(posedge clk);
        freq_change_req <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check(3'({req_ready, ddr2_cmd_if_inst.odt}), 3'h0);
        @(posedge clk);
        req_valid <= 1'b0;
        wait_idle(100);
        check({powered_down, dll_on, contents_valid}, 3'h3);
        check(3'(ddr2_cmd_if_inst.odt), 3'h1);
    endtask : t_freq

    // activate, write, read, precharge and refresh; bursts run whole under nop
    task automatic t_burst();
        cmd_type seq [5] = '{CMD_ACT, CMD_WR, CMD_RD, CMD_PRE, CMD_REF};
        foreach (seq[i]) begin
            issue(seq[i], 1'b0);
            if (seq[i] == CMD_WR || seq[i] == CMD_RD) begin
                check({burst_busy, cmd_error, req_ready}, 3'h4);
            end
        end
    endtask : t_burst

    // cke lost mid-burst, then full re-initialisation
    task automatic t_fail();
        issue(CMD_RD, 1'b1);
        repeat (4) @(posedge clk);
        #1;
        check({contents_valid, ddr2_cmd_if_inst.clk_run,
               ddr2_cmd_if_inst.cke}, 3'h0);
        @(posedge clk);
        cke_fail <= 1'b0;
        wait_idle(400);
        check({contents_valid, dll_on, powered_down}, 3'h6);
    endtask : t_fail

    task automatic final_report();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_idle();
        t_freq(1'b1);
        t_burst();
        t_fail();
        t_freq(1'b0);
        final_report();
    end
endmodule : ddr2_lowpower_clock_change_nop_test
